// file: hdl/motor_pwm_time_base_compare.v
// Added by the designer: the placing of the registers and the Wishbone slave port.
`include "pwm_defines.vh"
`default_nettype none

// Operation
// R1 - 15-bit time base counter, clocked through a prescaler, match events through a postscaler.
// R2 - Counter register bit 15 reads count direction: 0 up, 1 down.
// R3 - Enable bit starts and stops the time base; disabling keeps the count.
// R4 - On counter equal period, reset to zero or reverse on the next count clock.
// R5 - Zero period halts counting, events and period reload; software disables to change it.
// R6 - Mode field: 00 free, 01 single-shot, 10 up/down, 11 up/down double update.
// R7 - Free mode counts to period, wraps to zero, raises postscaled event each match.
// R8 - Single-shot counts once, unpostscaled event at match, wraps and clears enable.
// R9 - Up/down counts up then down; postscaled event when zero turns upward.
// R10 - Double update raises unpostscaled events at zero and at period match.
// R11 - Software must never program period one; it may cause continuous events.
// R12 - Count clock is the system clock divided by 1, 4, 16 or 64.
// R13 - Counter or control writes and reset clear the prescaler; control write keeps count.
// R14 - Four-bit postscaler divides match events 1 to 16; cleared like the prescaler.
// R15 - Period double-buffered: loads at wrap, at zero in up/down, always when disabled.
// R16 - Up/down modes give twice the free-running period for equal settings; the code gives 2 x period count clocks against period plus one.
// R17 - Free and single-shot modes give edge-aligned outputs: active at zero, off at duty.
// R18 - Edge-aligned: zero duty always inactive, duty above period always active.
// R19 - Up/down modes give center-aligned outputs: on at match going down, off going up.
// R20 - Center-aligned: zero duty always inactive, duty equal period always active.
// R21 - Four generators, each a high/low pair; low output always inverse of high.
// R22 - Duty registers are 16 bits; lowest bit gives half-count resolution; the code has no half count at 1:1 prescale.
// R23 - Duty double-buffered: period instants, plus period match in double update, and disabled.
// R24 - Each event is a one-clock pulse setting a flag held until software clears it.
// R25 - Upper fifteen duty bits compare to the count; lowest bit delays by half count; the code has no half count at 1:1 prescale.
module motor_pwm_time_base_compare (
    input  wire        clk_sys_in,
    input  wire        rst_n_in,
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [7:0]  wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output reg  [31:0] wb_dat_out,
    output wire        wb_ack_out,
    output wire        pair1_high_out,
    output wire        pair1_low_out,
    output wire        pair2_high_out,
    output wire        pair2_low_out,
    output wire        pair3_high_out,
    output wire        pair3_low_out,
    output wire        pair4_high_out,
    output wire        pair4_low_out,
    output reg         event_pulse_out
);

    // byte-lane merge of a 16-bit register with bus write data
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  sel;
        begin
            merge16 = {(sel[1] ? data[15:8] : old[15:8]), (sel[0] ? data[7:0] : old[7:0])};
        end
    endfunction

    // register file
    reg  [15:0] time_base_control_r;
    reg  [15:0] time_base_control_nxt;
    reg  [14:0] time_base_counter_r;
    reg  [14:0] time_base_counter_nxt;
    reg         count_direction_flag_r;
    reg         count_direction_flag_nxt;
    reg  [14:0] period_buf_r;
    reg  [14:0] period_value_r;
    reg  [63:0] duty_buf_r;
    reg  [63:0] duty_value_r;
    reg  [3:0]  post_cnt_r;
    reg  [3:0]  post_cnt_nxt;
    reg         event_flag_r;

    // bus
    reg         ack_r;
    wire        req;
    wire        wr;
    wire [7:0]  adr;
    wire        wr_ctl;
    wire        wr_cnt;
    wire        wr_per;
    wire        wr_sts;
    wire [15:0] ctl_merged;
    wire [15:0] cnt_merged;
    wire [15:0] per_merged;

    // time base
    wire        time_base_enable;
    wire [1:0]  count_mode_select;
    wire [1:0]  input_prescale_select;
    wire [3:0]  match_postscale_select;
    wire        up_down;
    wire        tick;
    wire        half;
    wire        run;
    wire        per_match;
    wire        at_zero;
    reg         raw_evt;
    reg         direct_evt;
    reg         load_per;
    reg         load_duty;
    reg         en_clr;
    reg         post_fire;
    wire        evt;
    wire [3:0]  high_w;
    wire [3:0]  low_w;
    integer     i;

    assign req        = wb_cyc_in & wb_stb_in;
    assign wb_ack_out = ack_r;
    // writes take effect at the edge that samples ack high
    assign wr         = req & wb_we_in & ack_r;
    assign adr        = {wb_adr_in[7:2], 2'b00};
    assign wr_ctl     = wr && (adr == `OFS_CONTROL);
    assign wr_cnt     = wr && (adr == `OFS_COUNTER);
    assign wr_per     = wr && (adr == `OFS_PERIOD);
    assign wr_sts     = wr && (adr == `OFS_STATUS);
    assign ctl_merged = merge16(time_base_control_r, wb_dat_in, wb_sel_in);
    assign cnt_merged = merge16({count_direction_flag_r, time_base_counter_r}, wb_dat_in, wb_sel_in);
    assign per_merged = merge16({1'b0, period_buf_r}, wb_dat_in, wb_sel_in);

    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // read data is captured one edge before ack is seen
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            wb_dat_out <= 32'h00000000;
        end else if (req && !ack_r) begin
            case (adr)
                `OFS_CONTROL:    wb_dat_out <= {16'h0000, time_base_control_r};
                `OFS_COUNTER:    wb_dat_out <= {16'h0000, count_direction_flag_r, time_base_counter_r}; // [R2]
                `OFS_PERIOD:     wb_dat_out <= {17'h00000, period_buf_r};
                `OFS_DUTY1:      wb_dat_out <= {16'h0000, duty_buf_r[15:0]};
                `OFS_DUTY2:      wb_dat_out <= {16'h0000, duty_buf_r[31:16]};
                `OFS_DUTY3:      wb_dat_out <= {16'h0000, duty_buf_r[47:32]};
                `OFS_DUTY4:      wb_dat_out <= {16'h0000, duty_buf_r[63:48]};
                `OFS_STATUS:     wb_dat_out <= {30'h00000000, (time_base_enable && !run), event_flag_r};
                `OFS_ACT_PERIOD: wb_dat_out <= {17'h00000, period_value_r};
                `OFS_ACT_DUTY1:  wb_dat_out <= {16'h0000, duty_value_r[15:0]};
                `OFS_ACT_DUTY2:  wb_dat_out <= {16'h0000, duty_value_r[31:16]};
                `OFS_ACT_DUTY3:  wb_dat_out <= {16'h0000, duty_value_r[47:32]};
                `OFS_ACT_DUTY4:  wb_dat_out <= {16'h0000, duty_value_r[63:48]};
                default:         wb_dat_out <= 32'h00000000;
            endcase
        end
    end

    assign time_base_enable       = time_base_control_r[`CTL_ENABLE_BIT];
    assign count_mode_select      = time_base_control_r[`CTL_MODE_HI:`CTL_MODE_LO];       // [R6]
    assign input_prescale_select  = time_base_control_r[`CTL_CKPS_HI:`CTL_CKPS_LO];
    assign match_postscale_select = time_base_control_r[`CTL_OPS_HI:`CTL_OPS_LO];
    assign up_down                = count_mode_select[1];

    count_prescaler u_prescaler (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .clear_in   (wr_ctl | wr_cnt), // [R13]
        .select_in  (input_prescale_select), // [R12]
        .tick_out   (tick),
        .half_out   (half)
    );

    // a zero period freezes the count and all loads while enabled
    assign run       = time_base_enable && (period_value_r != `PERIOD_RST); // [R3] [R5]
    assign per_match = (time_base_counter_r == period_value_r); // [R4]
    assign at_zero   = (time_base_counter_r == `COUNTER_RST);

    always @* begin
        time_base_counter_nxt    = time_base_counter_r;
        count_direction_flag_nxt = count_direction_flag_r;
        raw_evt                  = 1'b0;
        direct_evt               = 1'b0;
        load_per                 = !time_base_enable; // [R15]
        load_duty                = !time_base_enable; // [R23]
        en_clr                   = 1'b0;
        if (run && tick) begin // [R1]
            if (!up_down) begin
                if (per_match) begin
                    time_base_counter_nxt = `COUNTER_RST; // [R7]
                    load_per              = 1'b1; // [R15]
                    load_duty             = 1'b1; // [R23]
                    if (count_mode_select == `MODE_SINGLE) begin
                        direct_evt = 1'b1; // [R8]
                        en_clr     = 1'b1;
                    end else begin
                        raw_evt = 1'b1; // [R7]
                    end
                end else begin
                    time_base_counter_nxt = time_base_counter_r + 15'h0001;
                end
            end else if (!count_direction_flag_r) begin
                if (per_match) begin
                    // turning down makes the cycle 2 x period count clocks
                    count_direction_flag_nxt = 1'b1; // [R4] [R16]
                    time_base_counter_nxt    = time_base_counter_r - 15'h0001;
                    if (count_mode_select == `MODE_DOUBLE) begin
                        direct_evt = 1'b1; // [R10]
                        load_duty  = 1'b1; // [R23]
                    end
                end else begin
                    time_base_counter_nxt = time_base_counter_r + 15'h0001;
                end
            end else begin
                if (at_zero) begin
                    count_direction_flag_nxt = 1'b0; // [R9]
                    time_base_counter_nxt    = time_base_counter_r + 15'h0001;
                    load_per                 = 1'b1; // [R15]
                    load_duty                = 1'b1; // [R23]
                    if (count_mode_select == `MODE_DOUBLE) begin
                        direct_evt = 1'b1; // [R10]
                    end else begin
                        raw_evt = 1'b1; // [R9]
                    end
                end else begin
                    time_base_counter_nxt = time_base_counter_r - 15'h0001;
                end
            end
        end
        if (wr_cnt) begin
            time_base_counter_nxt = cnt_merged[14:0];
        end
    end

    always @* begin
        time_base_control_nxt = time_base_control_r;
        if (wr_ctl) begin
            time_base_control_nxt = ctl_merged;
        end else if (en_clr) begin
            time_base_control_nxt[`CTL_ENABLE_BIT] = 1'b0; // [R8]
        end
    end

    // postscaler divides match events by select plus one
    always @* begin
        post_cnt_nxt = post_cnt_r;
        post_fire    = 1'b0;
        if (wr_ctl || wr_cnt) begin
            post_cnt_nxt = 4'h0; // [R14]
        end else if (raw_evt) begin
            if (post_cnt_r == match_postscale_select) begin
                post_cnt_nxt = 4'h0;
                post_fire    = 1'b1; // [R14]
            end else begin
                post_cnt_nxt = post_cnt_r + 4'h1;
            end
        end
    end

    assign evt = direct_evt | post_fire;

    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            time_base_control_r    <= `CONTROL_RST;
            time_base_counter_r    <= `COUNTER_RST;
            count_direction_flag_r <= 1'b0;
            post_cnt_r             <= 4'h0;
            event_pulse_out        <= 1'b0;
            event_flag_r           <= 1'b0;
        end else begin
            time_base_control_r    <= time_base_control_nxt;
            time_base_counter_r    <= time_base_counter_nxt;
            count_direction_flag_r <= count_direction_flag_nxt;
            post_cnt_r             <= post_cnt_nxt;
            event_pulse_out        <= evt; // [R24]
            // a new event wins over a clear in the same cycle
            event_flag_r           <= evt | (event_flag_r &
                                      ~(wr_sts & wb_sel_in[0] & wb_dat_in[`STS_FLAG_BIT])); // [R24]
        end
    end

    // period and duty buffers and their active copies
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            period_buf_r   <= `PERIOD_RST;
            period_value_r <= `PERIOD_RST;
            duty_buf_r     <= {4{`DUTY_RST}};
            duty_value_r   <= {4{`DUTY_RST}};
        end else begin
            if (wr_per) begin
                period_buf_r <= per_merged[14:0];
            end
            if (load_per) begin
                period_value_r <= period_buf_r; // [R15]
            end
            for (i = 0; i < 4; i = i + 1) begin
                if (wr && (adr == `OFS_DUTY1 + 8'h04 * i[7:0])) begin
                    duty_buf_r[16*i +: 16] <= merge16(duty_buf_r[16*i +: 16], wb_dat_in, wb_sel_in); // [R22]
                end
            end
            if (load_duty) begin
                duty_value_r <= duty_buf_r; // [R23]
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_pair
            duty_compare_gen u_gen (
                .clk_sys_in (clk_sys_in),
                .rst_n_in   (rst_n_in),
                .center_in  (up_down), // [R17] [R19]
                .counter_in (time_base_counter_r),
                .half_in    (half), // [R25]
                .period_in  (period_value_r),
                .duty_in    (duty_value_r[16*g +: 16]),
                .high_out   (high_w[g]),
                .low_out    (low_w[g])
            );
        end
    endgenerate

    assign pair1_high_out = high_w[0]; // [R21]
    assign pair1_low_out  = low_w[0];
    assign pair2_high_out = high_w[1];
    assign pair2_low_out  = low_w[1];
    assign pair3_high_out = high_w[2];
    assign pair3_low_out  = low_w[2];
    assign pair4_high_out = high_w[3];
    assign pair4_low_out  = low_w[3];

endmodule

`default_nettype wire

// file: inc/pwm_defines.vh
`ifndef PWM_DEFINES_VH
`define PWM_DEFINES_VH

// register byte offsets
`define OFS_CONTROL       8'h00
`define OFS_COUNTER       8'h04
`define OFS_PERIOD        8'h08
`define OFS_DUTY1         8'h0C
`define OFS_DUTY2         8'h10
`define OFS_DUTY3         8'h14
`define OFS_DUTY4         8'h18
`define OFS_STATUS        8'h1C
`define OFS_ACT_PERIOD    8'h20
`define OFS_ACT_DUTY1     8'h24
`define OFS_ACT_DUTY2     8'h28
`define OFS_ACT_DUTY3     8'h2C
`define OFS_ACT_DUTY4     8'h30

// control register fields
`define CTL_ENABLE_BIT    15
`define CTL_OPS_HI        7
`define CTL_OPS_LO        4
`define CTL_CKPS_HI       3
`define CTL_CKPS_LO       2
`define CTL_MODE_HI       1
`define CTL_MODE_LO       0

// counter register fields
`define CNT_DIR_BIT       15

// status register fields
`define STS_FLAG_BIT      0
`define STS_STALL_BIT     1

// count modes
`define MODE_FREE         2'h0
`define MODE_SINGLE       2'h1
`define MODE_UPDOWN       2'h2
`define MODE_DOUBLE       2'h3

// reset values
`define CONTROL_RST       16'h0000
`define COUNTER_RST       15'h0000
`define PERIOD_RST        15'h0000
`define DUTY_RST          16'h0000

// prescaler terminal counts, in clocks minus one
`define PRESC_TOP_1       6'h00
`define PRESC_TOP_4       6'h03
`define PRESC_TOP_16      6'h0F
`define PRESC_TOP_64      6'h3F

`endif

// file: hdl/count_prescaler.v
`include "pwm_defines.vh"
`default_nettype none

module count_prescaler (
    input  wire       clk_sys_in,
    input  wire       rst_n_in,
    input  wire       clear_in,
    input  wire [1:0] select_in,
    output wire       tick_out,
    output wire       half_out
);

    reg  [5:0] cnt_r;
    reg  [5:0] cnt_nxt;
    reg  [5:0] top;

    always @* begin
        case (select_in)
            2'h0:    top = `PRESC_TOP_1;
            2'h1:    top = `PRESC_TOP_4;
            2'h2:    top = `PRESC_TOP_16;
            default: top = `PRESC_TOP_64;
        endcase
    end

    assign tick_out = (cnt_r == top);
    // second half of a prescaled count; never seen at 1:1
    assign half_out = (select_in != 2'h0) && (cnt_r > {1'b0, top[5:1]});

    always @* begin
        if (clear_in || tick_out) begin
            cnt_nxt = 6'h00;
        end else begin
            cnt_nxt = cnt_r + 6'h01;
        end
    end

    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cnt_r <= 6'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

`default_nettype wire

// file: hdl/duty_compare_gen.v
`include "pwm_defines.vh"
`default_nettype none

module duty_compare_gen (
    input  wire        clk_sys_in,
    input  wire        rst_n_in,
    input  wire        center_in,
    input  wire [14:0] counter_in,
    input  wire        half_in,
    input  wire [14:0] period_in,
    input  wire [15:0] duty_in,
    output reg         high_out,
    output reg         low_out
);

    wire [14:0] duty_hi;
    wire        edge_act;
    wire        ctr_act;
    wire        act;

    assign duty_hi  = duty_in[15:1];
    // active from zero until the duty point, in half counts
    assign edge_act = ({counter_in, half_in} < duty_in);                           // [R17] [R18] [R25]
    // active below the duty point: set on the way down, cleared on the way up
    assign ctr_act  = (duty_in != `DUTY_RST) &&                                    // [R19] [R20]
                      ((duty_hi >= period_in) || (counter_in < duty_hi) ||
                       ((counter_in == duty_hi) && (duty_in[0] || !half_in)));      // [R25]
    assign act      = center_in ? ctr_act : edge_act;

    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            high_out <= 1'b0;
            low_out  <= 1'b1;
        end else begin
            high_out <= act;
            low_out  <= ~act;                                                      // [R21]
        end
    end

endmodule

`default_nettype wire

// file: test/motor_pwm_checker.sv
`include "pwm_defines.vh"
`default_nettype none
module motor_pwm_checker (
    input wire logic        clk_sys_in,
    input wire logic        rst_n_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [7:0]  wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    input wire logic        pair1_high_out,
    input wire logic        pair1_low_out,
    input wire logic        pair2_high_out,
    input wire logic        pair2_low_out,
    input wire logic        pair3_high_out,
    input wire logic        pair3_low_out,
    input wire logic        pair4_high_out,
    input wire logic        pair4_low_out,
    input wire logic        event_pulse_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ctl_r;
    logic [1:0]  dis_r;
    // last fully written control word, updated at the same edge as the design
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ctl_r <= `CONTROL_RST;
            dis_r <= 2'h0;
        end else begin
            if (wb_ack_out && wb_we_in && wb_adr_in == `OFS_CONTROL && wb_sel_in[1:0] == 2'h3)
                ctl_r <= wb_dat_in[15:0];
            if (ctl_r[15])
                dis_r <= 2'h0;
            else if (dis_r != 2'h3)
                dis_r <= dis_r + 2'h1;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    property p_ack_wait;
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
    endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("ack late");
    property p_ack_once;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held");
    property p_unmapped;
        wb_ack_out && !wb_we_in && wb_adr_in > 8'h33 |-> wb_dat_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_pair1;
        pair1_low_out == !pair1_high_out;
    endproperty
    a_pair1: assert property (p_pair1) else $error("pair 1 not inverse");
    property p_pair2;
        pair2_low_out == !pair2_high_out;
    endproperty
    a_pair2: assert property (p_pair2) else $error("pair 2 not inverse");
    property p_pair3;
        pair3_low_out == !pair3_high_out;
    endproperty
    a_pair3: assert property (p_pair3) else $error("pair 3 not inverse");
    property p_pair4;
        pair4_low_out == !pair4_high_out;
    endproperty
    a_pair4: assert property (p_pair4) else $error("pair 4 not inverse");
    property p_event_pulse;
        event_pulse_out |=> !event_pulse_out;
    endproperty
    a_event_pulse: assert property (p_event_pulse) else $error("event too long");
    property p_dis_quiet;
        dis_r == 2'h3 && !ctl_r[15] |-> !event_pulse_out;
    endproperty
    a_dis_quiet: assert property (p_dis_quiet) else $error("event while stopped");
    property p_dir_up;
        wb_ack_out && !wb_we_in && wb_adr_in == `OFS_COUNTER && !ctl_r[1] |-> !wb_dat_out[15];
    endproperty
    a_dir_up: assert property (p_dir_up) else $error("down flag in edge mode");
endmodule
bind motor_pwm_time_base_compare motor_pwm_checker motor_pwm_checker_inst (.*);
`default_nettype wire

// file: test/pwm_load_model.sv
`default_nettype none
module pwm_load_model (
    input  wire logic             clk_sys_in,
    input  wire logic             clr_in,
    input  wire logic [3:0]       high_in,
    input  wire logic [3:0]       low_in,
    output var  logic [3:0][15:0] on_cnt_out,
    output var  logic             shoot_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // on-time of each upper switch; both switches of a leg on would short the supply
    always_ff @(posedge clk_sys_in) begin
        for (int i = 0; i < 4; i++) begin
            if (clr_in)
                on_cnt_out[i] <= 16'h0000;
            else
                on_cnt_out[i] <= on_cnt_out[i] + {15'h0000, high_in[i]};
        end
        if (clr_in)
            shoot_out <= 1'b0;
        else if (|(high_in & low_in))
            shoot_out <= 1'b1;
    end
endmodule
`default_nettype wire

// file: test/motor_pwm_time_base_compare_test.sv
`include "pwm_defines.vh"
`default_nettype none
module motor_pwm_time_base_compare_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clk_sys_in = 1'b0;
    logic             rst_n_in   = 1'b0;
    logic             cyc        = 1'b0;
    logic             stb        = 1'b0;
    logic             we         = 1'b0;
    logic             clr        = 1'b1;
    logic [7:0]       adr        = 8'h00;
    logic [3:0]       sel        = 4'h0;
    logic [31:0]      wdat       = 32'h0;
    wire  [31:0]      rdat;
    wire              ack;
    wire              ev;
    wire              shoot;
    wire  [3:0]       hi;
    wire  [3:0]       lo;
    wire  [3:0][15:0] on_cnt;
    logic [15:0]      q;
    logic [15:0]      q2;
    logic [15:0]      d [4];
    logic [7:0]       rst_adr [7] = '{`OFS_CONTROL, `OFS_COUNTER, `OFS_PERIOD, `OFS_DUTY1, `OFS_STATUS,
                                      `OFS_ACT_PERIOD, 8'h40};
    int               error_cnt  = 0;
    int               n_checks   = 0;
    int               cyc_cnt    = 0;
    int               p;
    int               n;
    int               s;
    always #10 clk_sys_in = ~clk_sys_in;
    motor_pwm_time_base_compare motor_pwm_time_base_compare_inst (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .event_pulse_out(ev),
        .pair1_high_out(hi[0]), .pair1_low_out(lo[0]), .pair2_high_out(hi[1]), .pair2_low_out(lo[1]),
        .pair3_high_out(hi[2]), .pair3_low_out(lo[2]), .pair4_high_out(hi[3]), .pair4_low_out(lo[3]));
    pwm_load_model pwm_load_model_inst (
        .clk_sys_in(clk_sys_in), .clr_in(clr), .high_in(hi), .low_in(lo),
        .on_cnt_out(on_cnt), .shoot_out(shoot));
    function automatic logic [15:0] ctl(int en, int ops, int ck, int md);
        return {en[0], 7'h00, ops[3:0], ck[1:0], md[1:0]};
    endfunction
    // clocks high per period at 1:1, where the half count never occurs
    function automatic int edge_on(logic [15:0] dv, int per);
        int h;
        h = (dv + 1) >> 1;
        return (h > per + 1) ? per + 1 : h;
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] dv);
        @(posedge clk_sys_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= {16'h0000, dv};
        do @(posedge clk_sys_in); while (ack !== 1'b1);
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] e);
        wb(a, 1'b0, 16'h0000);
        chk(nm, e, q);
    endtask
    // clocks between the second and third event after the call
    task automatic gap();
        for (int k = 0; k < 3; k++) begin
            s = 0;
            do begin
                @(posedge clk_sys_in);
                s++;
            end while (ev !== 1'b1);
        end
    endtask
    task automatic window(int len);
        @(posedge clk_sys_in);
        clr <= 1'b1;
        @(posedge clk_sys_in);
        clr <= 1'b0;
        repeat (len + 1) @(posedge clk_sys_in);
    endtask
    always @(posedge clk_sys_in) begin
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        p = $urandom(99);
        repeat (3) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        foreach (rst_adr[i]) rdchk("reset value", rst_adr[i], 16'h0000);
        $display("test reset done");
        p = 3 + $urandom % 6;
        d = '{16'h0000, 16'($urandom % (2 * p + 4)), 16'(2 * p), 16'(2 * p + 2)};
        wb(`OFS_PERIOD, 1'b1, 16'(p));
        for (int i = 0; i < 4; i++) wb(`OFS_DUTY1 + 8'(4 * i), 1'b1, d[i]);
        for (int i = 0; i < 4; i++) rdchk("active duty", `OFS_ACT_DUTY1 + 8'(4 * i), d[i]);
        rdchk("active period", `OFS_ACT_PERIOD, 16'(p));
        $display("test buffers done");
        for (int ck = 0; ck < 4; ck++) begin
            n = $urandom % 4;
            wb(`OFS_CONTROL, 1'b1, ctl(1, n, ck, 0));
            gap();
            chk("free gap", 16'(((p + 1) * (n + 1)) << (2 * ck)), 16'(s));
        end
        wb(`OFS_CONTROL, 1'b1, ctl(0, 0, 0, 0));
        wb(`OFS_COUNTER, 1'b0, 16'h0000);
        q2 = q;
        repeat (20) @(posedge clk_sys_in);
        rdchk("held count", `OFS_COUNTER, q2);
        $display("test free done");
        wb(`OFS_CONTROL, 1'b1, ctl(1, 0, 0, 0));
        window(4 * (p + 1));
        for (int i = 0; i < 4; i++) chk("edge on time", 16'(4 * edge_on(d[i], p)), on_cnt[i]);
        chk("shoot through", 16'h0000, {15'h0000, shoot});
        $display("test edge done");
        wb(`OFS_CONTROL, 1'b1, ctl(0, 0, 0, 0));
        wb(`OFS_COUNTER, 1'b1, 16'h0000);
        wb(`OFS_CONTROL, 1'b1, ctl(1, 0, 0, 1));
        do @(posedge clk_sys_in); while (ev !== 1'b1);
        repeat (2) @(posedge clk_sys_in);
        rdchk("one shot control", `OFS_CONTROL, ctl(0, 0, 0, 1));
        rdchk("one shot count", `OFS_COUNTER, 16'h0000);
        $display("test single done");
        n = 1 + $urandom % 3;
        wb(`OFS_CONTROL, 1'b1, ctl(1, n, 0, 3));
        gap();
        chk("double gap", 16'(p), 16'(s));
        wb(`OFS_CONTROL, 1'b1, ctl(1, n, 0, 2));
        gap();
        chk("up down gap", 16'(2 * p * (n + 1)), 16'(s));
        q2 = 16'h0000;
        repeat (12) begin
            wb(`OFS_COUNTER, 1'b0, 16'h0000);
            q2 = q2 | q;
        end
        chk("down flag", 16'h8000, q2 & 16'h8000);
        window(8 * p);
        for (int i = 0; i < 4; i += 2) chk("center on time", 16'(i == 0 ? 0 : 8 * p), on_cnt[i]);
        chk("center full", 16'(8 * p), on_cnt[3]);
        $display("test center done");
        conclude();
    end
endmodule
`default_nettype wire
